// [rtl/fetch_pkg.sv]
package fetch_pkg;
  localparam int          ADDR_W      = 32;
  localparam int          DATA_W      = 32;
  localparam int          LINE_WORDS  = 8;
  localparam int          GEN_ENTRIES = 15;
  localparam int          ENTRIES     = 16;
  localparam int          FIFO_DEPTH  = 8;
  localparam logic [3:0]  VEC_IDX     = 4'hF;
  localparam logic [3:0]  AGE_MAX     = 4'hE;
  localparam logic [2:0]  LAST_WORD   = 3'h7;
  localparam logic [31:0] WORD_STEP   = 32'h0000_0004;
  localparam logic [31:0] LINE_STEP   = 32'h0000_0020;
  localparam logic [31:0] RESET_ADDR  = 32'h0000_0000;

  typedef enum logic [1:0] {
    FL_IDLE = 2'b00,
    FL_PREF = 2'b01,
    FL_LIT  = 2'b10
  } flash_state_e;

  typedef struct packed {
    logic        req;
    logic [31:0] addr;
  } addr_req_s;

  typedef struct packed {
    logic        ack;
    logic [31:0] data;
  } flash_rsp_s;

  typedef struct packed {
    flash_state_e                  flashState;
    logic                          discard;
    logic                          flashReq;
    logic [31:0]                   flashAddr;
    logic [31:0]                   fetchPtr;
    logic [31:0]                   expAddr;
    logic                          instrValid;
    logic [31:0]                   instrData;
    logic                          litValid;
    logic [31:0]                   litData;
    logic                          hitActive;
    logic [3:0]                    hitIdx;
    logic [2:0]                    hitCnt;
    logic                          filling;
    logic [3:0]                    fillIdx;
    logic [2:0]                    fillCnt;
    logic [15:0]                   valid;
    logic [15:0][31:0]             tag;
    logic [15:0][7:0][31:0]        data;
    logic [14:0][3:0]              age;
  } fetch_state_s;

  // recency ranks start as a permutation of the general entries
  function automatic logic [14:0][3:0] age_init();
    for (int i = 0; i < GEN_ENTRIES; i++) age_init[i] = 4'(i);
  endfunction
endpackage

// [rtl/flash_prefetch_branch_cache.sv]
// Function
// - queue holds eight instructions ahead
// - fifteen general branch target entries
// - prefetch runs ahead in idle flash cycles
// - each flash access moves one 32-bit word
// - non-sequential fetch looks up cache first
// - entry keeps target and eight instructions
// - all entries compared in parallel
// - hit streams line, prefetch resumes after it
// - miss flushes queue, core stalls for flash
// - sixteenth entry reserved for vector read
// - literal reads leave queue intact
`timescale 1ns/100ps

// prefetch queue storage
module prefetch_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             flush,
  // fill side
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  // drain side
  output logic                  outValid,
  output logic [WIDTH-1:0]      outData,
  input  wire logic             outReady
);
  // pointer and fill level widths
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  // whole queue state, registered as one word
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               rd;
    logic [AW-1:0]               wr;
    logic [CW-1:0]               cnt;
  } fifo_state_s;
  fifo_state_s s_reg;
  fifo_state_s s_next;
  logic        doPush;
  logic        doPop;

  // handshake flags from the current fill level
  assign inReady  = s_reg.cnt != CW'(DEPTH);
  assign outValid = s_reg.cnt != '0;
  assign outData  = s_reg.mem[s_reg.rd];
  assign doPush   = inValid && inReady;
  assign doPop    = outValid && outReady;

  // pointer and count update, flush empties the queue
  always_comb begin
    s_next = s_reg;
    if (flush) begin
      // flush wins over a push in the same cycle
      s_next.rd  = '0;
      s_next.wr  = '0;
      s_next.cnt = '0;
    end else begin
      // write at the tail; the level follows push and pop
      if (doPush) begin
        s_next.mem[s_reg.wr] = inData;
        s_next.wr            = s_reg.wr + AW'(1);
      end
      if (doPop) s_next.rd = s_reg.rd + AW'(1);
      s_next.cnt = s_reg.cnt + CW'(doPush) - CW'(doPop);
    end
  end

  // state register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule

// instruction fetch path with prefetch queue and branch target cache
module flash_prefetch_branch_cache #(
  parameter logic [31:0] VEC_ADDR = 32'h0000_0018
) (
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  // instruction_coupled_port fetch
  input  wire fetch_pkg::addr_req_s fetch,
  output logic                      instrValid,
  output logic [31:0]               instrData,
  // literal data read
  input  wire fetch_pkg::addr_req_s lit,
  output logic                      litValid,
  output logic [31:0]               litData,
  // burst flash
  output logic                      flashReq,
  output logic [31:0]               flashAddr,
  input  wire fetch_pkg::flash_rsp_s flashRsp
);
  // recency ranks loaded by reset, a constant permutation
  localparam logic [14:0][3:0] AGE_RESET = fetch_pkg::age_init();
  // registered state and its next value
  fetch_pkg::fetch_state_s s_reg;
  fetch_pkg::fetch_state_s s_next;
  // queue handshake
  logic        fifoFlush;
  logic        pushValid;
  logic        fifoInReady;
  logic        fifoOutValid;
  logic [31:0] fifoOutData;
  logic        fifoPop;
  // lookup and replacement results
  logic        hitAny;
  logic [3:0]  hitSel;
  logic        freeAny;
  logic [3:0]  victim;

  // prefetch_queue: eight words of look-ahead
  prefetch_fifo #(
    .WIDTH (fetch_pkg::DATA_W),
    .DEPTH (fetch_pkg::FIFO_DEPTH)
  ) prefetch_queue (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .flush    (fifoFlush),
    .inValid  (pushValid && !fifoFlush),
    .inData   (flashRsp.data),
    .inReady  (fifoInReady),
    .outValid (fifoOutValid),
    .outData  (fifoOutData),
    .outReady (fifoPop)
  );

  // parallel tag match over every entry
  always_comb begin
    hitAny = 1'b0;
    hitSel = 4'h0;
    for (int i = 0; i < fetch_pkg::ENTRIES; i++) begin
      // at most one entry can hold a given target
      if (s_reg.valid[i] && s_reg.tag[i] == fetch.addr) begin
        hitAny = 1'b1;
        hitSel = 4'(i);
      end
    end
  end

  // replacement choice: lowest free general entry, else the oldest
  always_comb begin
    freeAny = 1'b0;
    victim  = 4'h0;
    for (int i = fetch_pkg::GEN_ENTRIES - 1; i >= 0; i--) begin
      if (!s_reg.valid[i]) begin
        freeAny = 1'b1;
        victim  = 4'(i);
      end
    end
    // all general entries valid: take the least recent
    if (!freeAny) begin
      for (int i = 0; i < fetch_pkg::GEN_ENTRIES; i++) begin
        if (s_reg.age[i] == fetch_pkg::AGE_MAX) victim = 4'(i);
      end
    end
  end

  // next-state logic for flash port, queue and cache
  always_comb begin
    logic [3:0] useIdx;
    logic       useGen;
    // defaults: pulses drop, queue and cache untouched
    useIdx       = 4'h0;
    useGen       = 1'b0;
    s_next       = s_reg;
    s_next.instrValid = 1'b0;
    s_next.litValid   = 1'b0;
    fifoFlush    = 1'b0;
    pushValid    = 1'b0;
    fifoPop      = 1'b0;

    // flash answers: one word per access
    if (flashRsp.ack && s_reg.flashState == fetch_pkg::FL_PREF) begin
      s_next.flashState = fetch_pkg::FL_IDLE;
      s_next.flashReq   = 1'b0;
      s_next.discard    = 1'b0;
      // a word in flight at a branch is dropped, never queued
      if (!s_reg.discard) begin
        pushValid = 1'b1;
        if (s_reg.filling) begin
          s_next.data[s_reg.fillIdx][s_reg.fillCnt] = flashRsp.data;
          s_next.fillCnt = s_reg.fillCnt + 3'h1;
          // line becomes valid only with its eighth word
          if (s_reg.fillCnt == fetch_pkg::LAST_WORD) begin
            s_next.filling              = 1'b0;
            s_next.valid[s_reg.fillIdx] = 1'b1;
          end
        end
      end
    end else if (flashRsp.ack && s_reg.flashState == fetch_pkg::FL_LIT) begin
      // literal answers bypass the queue
      s_next.flashState = fetch_pkg::FL_IDLE;
      s_next.flashReq   = 1'b0;
      s_next.litValid   = 1'b1;
      s_next.litData    = flashRsp.data;
    end

    // core fetch handling
    // the pulse edge refuses a request: one word per two cycles
    if (fetch.req && !s_reg.instrValid) begin
      if (fetch.addr != s_reg.expAddr) begin
        // branch: look up cache before reloading the queue
        fifoFlush      = 1'b1;
        s_next.discard = s_reg.flashState == fetch_pkg::FL_PREF && !flashRsp.ack;
        s_next.expAddr = fetch.addr;
        s_next.filling = 1'b0;
        if (hitAny) begin
          // hit: stream the stored line, refill after it
          s_next.hitActive = 1'b1;
          s_next.hitIdx    = hitSel;
          s_next.hitCnt    = 3'h0;
          s_next.fetchPtr  = fetch.addr + fetch_pkg::LINE_STEP;
          useIdx = hitSel;
          useGen = hitSel != fetch_pkg::VEC_IDX;
        end else begin
          // miss: stall on flash and capture the line
          s_next.hitActive = 1'b0;
          s_next.fetchPtr  = fetch.addr;
          s_next.filling   = 1'b1;
          s_next.fillCnt   = 3'h0;
          // the vector read owns the last entry
          if (fetch.addr == VEC_ADDR) begin
            s_next.fillIdx = fetch_pkg::VEC_IDX;
          end else begin
            s_next.fillIdx = victim;
            useIdx = victim;
            useGen = 1'b1;
          end
          // entry stays invalid until its fill completes
          s_next.valid[s_next.fillIdx] = 1'b0;
          s_next.tag[s_next.fillIdx]   = fetch.addr;
        end
      end else if (s_reg.hitActive) begin
        // stream stored line while the queue refills
        s_next.instrValid = 1'b1;
        s_next.instrData  = s_reg.data[s_reg.hitIdx][s_reg.hitCnt];
        s_next.hitCnt     = s_reg.hitCnt + 3'h1;
        s_next.expAddr    = s_reg.expAddr + fetch_pkg::WORD_STEP;
        if (s_reg.hitCnt == fetch_pkg::LAST_WORD) s_next.hitActive = 1'b0;
      end else if (fifoOutValid) begin
        // sequential word from the prefetch queue
        fifoPop           = 1'b1;
        s_next.instrValid = 1'b1;
        s_next.instrData  = fifoOutData;
        s_next.expAddr    = s_reg.expAddr + fetch_pkg::WORD_STEP;
      end
    end

    // recency update on general-entry hit or allocation
    if (useGen) begin
      // entries newer than the used one age by one
      for (int j = 0; j < fetch_pkg::GEN_ENTRIES; j++) begin
        if (s_reg.age[j] < s_reg.age[useIdx]) s_next.age[j] = s_reg.age[j] + 4'h1;
      end
      s_next.age[useIdx] = 4'h0;
    end

    // flash issue: literal first, prefetch in otherwise idle cycles
    if (s_reg.flashState == fetch_pkg::FL_IDLE) begin
      // one access outstanding; a flush restarts at once
      if (lit.req && !s_reg.litValid) begin
        s_next.flashState = fetch_pkg::FL_LIT;
        s_next.flashReq   = 1'b1;
        s_next.flashAddr  = lit.addr;
      end else if (fifoInReady || fifoFlush) begin
        // look ahead while the queue has room
        s_next.flashState = fetch_pkg::FL_PREF;
        s_next.flashReq   = 1'b1;
        s_next.flashAddr  = s_next.fetchPtr;
        s_next.fetchPtr   = s_next.fetchPtr + fetch_pkg::WORD_STEP;
      end
    end
  end

  // state register, every cache entry invalid after reset
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_reg          <= '0;
      s_reg.fetchPtr <= fetch_pkg::RESET_ADDR;
      s_reg.expAddr  <= fetch_pkg::RESET_ADDR;
      s_reg.age      <= AGE_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state register
  assign instrValid = s_reg.instrValid;
  assign instrData  = s_reg.instrData;
  assign litValid   = s_reg.litValid;
  assign litData    = s_reg.litData;
  assign flashReq   = s_reg.flashReq;
  assign flashAddr  = s_reg.flashAddr;
endmodule

// [testbench/flash_prefetch_branch_cache_props.sv]
`timescale 1ns/100ps
// port watcher for the fetch path
module flash_prefetch_branch_cache_props (
  // clock and reset
  input wire logic                  sys_clk,
  input wire logic                  rst,
  // core side
  input wire fetch_pkg::addr_req_s  fetch,
  input wire logic                  instrValid,
  input wire logic [31:0]           instrData,
  input wire fetch_pkg::addr_req_s  lit,
  input wire logic                  litValid,
  input wire logic [31:0]           litData,
  // flash side
  input wire logic                  flashReq,
  input wire logic [31:0]           flashAddr,
  input wire fetch_pkg::flash_rsp_s flashRsp
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // flash request stands with its address until answered
  AST_REQ_HOLD: assert property (flashReq && !flashRsp.ack |=> flashReq && $stable(flashAddr))
    else $error("flash request dropped or moved before ack");
  AST_REQ_GAP: assert property (flashReq && flashRsp.ack |=> !flashReq)
    else $error("no idle cycle after flash ack");
  AST_WORD_ALIGN: assert property (flashReq |-> flashAddr[1:0] == 2'b00)
    else $error("flash address not word aligned");
  AST_START_FETCH: assert property ($fell(rst) |=> flashReq && flashAddr == 32'h0000_0000)
    else $error("prefetch did not start at reset address");
  AST_INSTR_PULSE: assert property (instrValid |=> !instrValid)
    else $error("instruction valid longer than one cycle");
  AST_INSTR_CAUSE: assert property (instrValid |-> $past(fetch.req))
    else $error("instruction delivered without request");
  AST_LIT_DATA: assert property (litValid |-> $past(flashRsp.ack) && litData == $past(flashRsp.data))
    else $error("literal word not the flash answer");
  AST_LIT_PULSE: assert property (litValid |=> !litValid ##1 !litValid)
    else $error("literal valid repeated");
  AST_LIT_IDLE: assert property (litValid |-> !flashReq)
    else $error("flash busy as literal delivered");
endmodule

bind flash_prefetch_branch_cache flash_prefetch_branch_cache_props i_props (
  .sys_clk(sys_clk), .rst(rst), .fetch(fetch), .instrValid(instrValid), .instrData(instrData),
  .lit(lit), .litValid(litValid), .litData(litData), .flashReq(flashReq), .flashAddr(flashAddr),
  .flashRsp(flashRsp));

// [testbench/flash_model.sv]
`timescale 1ns/100ps
// burst flash: one word per request after lat cycles
module flash_model (
  // clock and reset
  input wire logic                sys_clk,
  input wire logic                rst,
  // answer delay
  input wire logic [3:0]          lat,
  // request and answer
  input wire logic                flashReq,
  input wire logic [31:0]         flashAddr,
  output fetch_pkg::flash_rsp_s   flashRsp
);
  logic [3:0] waitCnt;
  // word is the inverted address; bus toggles between answers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      waitCnt <= 4'h0;
      flashRsp <= '0;
    end else if (flashReq && !flashRsp.ack && waitCnt + 4'h1 >= lat) begin
      flashRsp.ack <= 1'b1;
      flashRsp.data <= ~flashAddr;
      waitCnt <= 4'h0;
    end else begin
      flashRsp.ack <= 1'b0;
      flashRsp.data <= ~flashRsp.data;
      waitCnt <= (flashReq && !flashRsp.ack) ? waitCnt + 4'h1 : 4'h0;
    end
  end
endmodule

// [testbench/testbench.sv]
`timescale 1ns/100ps
module testbench;
  localparam logic [31:0] VEC = 32'h0000_0018;
  logic                  sys_clk = 1'b0;
  logic                  rst = 1'b1;
  fetch_pkg::addr_req_s  fetch = '0;
  fetch_pkg::addr_req_s  lit = '0;
  fetch_pkg::flash_rsp_s flashRsp;
  logic                  instrValid, litValid, flashReq;
  logic [31:0]           instrData, litData, flashAddr;
  logic [3:0]            lat = 4'h1;
  int                    n_errors = 0;
  int                    checks_done = 0;
  int                    n, maxN;
  // 20 MHz clock
  always #25 sys_clk = ~sys_clk;
  flash_prefetch_branch_cache #(.VEC_ADDR(VEC)) i_flash_prefetch_branch_cache (.sys_clk(sys_clk), .rst(rst),
    .fetch(fetch), .instrValid(instrValid), .instrData(instrData), .lit(lit), .litValid(litValid),
    .litData(litData), .flashReq(flashReq), .flashAddr(flashAddr), .flashRsp(flashRsp));
  flash_model i_flash_model (.sys_clk(sys_clk), .rst(rst), .lat(lat), .flashReq(flashReq),
    .flashAddr(flashAddr), .flashRsp(flashRsp));
  // compare helpers
  task automatic chk_word(string what, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk_flag(string what, logic e, logic g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %b seen %b", what, e, g);
    end
  endtask
  // one fetch from a falling edge; n counts edges to delivery
  task automatic get(input logic [31:0] a);
    fetch.req = 1'b1;
    fetch.addr = a;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (instrValid !== 1'b1 && n < 60);
    chk_flag("instr arrived", 1'b1, instrValid === 1'b1);
    chk_word("instr", ~a, instrData);
    if (n > maxN) maxN = n;
  endtask
  // eight words from a branch target
  task automatic line(input logic [31:0] a);
    for (int i = 0; i < 8; i++) get(a + 32'(i * 4));
  endtask
  // idle the core for c cycles
  task automatic idle(input int c);
    fetch.req = 1'b0;
    repeat (c) @(negedge sys_clk);
  endtask
  task automatic t_seq();
    line(32'h0000_0000);
    line(32'h0000_0020);
    idle(30);
    maxN = 0;
    line(32'h0000_0040);
    chk_flag("queue ahead", 1'b1, maxN <= 2);
    $display("done sequential");
  endtask
  task automatic t_branch();
    lat = 4'h3;
    get(32'h0000_0400);
    chk_flag("miss stall", 1'b1, n >= 4);
    line(32'h0000_0404);
    line(32'h0000_0800);
    // a hit answers on the edge after its lookup edge
    get(32'h0000_0400);
    chk_flag("hit first", 1'b1, n <= 3);
    maxN = 0;
    for (int i = 1; i < 8; i++) get(32'h0000_0400 + 32'(i * 4));
    chk_flag("hit line", 1'b1, maxN <= 2);
    get(32'h0000_0420);
    $display("done branch");
  endtask
  task automatic t_lit();
    idle(20);
    lit.req = 1'b1;
    lit.addr = 32'h0000_1000;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (litValid !== 1'b1 && n < 60);
    chk_flag("literal arrived", 1'b1, litValid === 1'b1);
    chk_word("literal", ~32'h0000_1000, litData);
    lit.req = 1'b0;
    get(32'h0000_0424);
    chk_flag("queue kept", 1'b1, n <= 2);
    $display("done literal");
  endtask
  task automatic t_vec();
    line(VEC);
    line(32'h0000_2000);
    get(VEC);
    chk_flag("vector hit", 1'b1, n <= 3);
    $display("done vector");
  endtask
  task automatic t_lru();
    for (int k = 0; k < 16; k++) line(32'h0000_3000 + 32'(k * 256));
    get(32'h0000_3000);
    chk_flag("oldest evicted", 1'b1, n >= 4);
    get(32'h0000_3200);
    chk_flag("fifteen kept", 1'b1, n <= 3);
    idle(1);
    $display("done replacement");
  endtask
  // verdict
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // watchdog well past the expected run
  initial begin
    #(50 * 20000);
    n_errors++;
    end_of_test();
  end
  // main sequence
  initial begin
    repeat (4) @(negedge sys_clk);
    rst = 1'b0;
    @(negedge sys_clk);
    t_seq();
    t_branch();
    t_lit();
    t_vec();
    t_lru();
    end_of_test();
  end
endmodule
